/* File: hdl/bidir_fifo_pkg.sv */
`default_nettype none

package bidir_fifo_pkg;

    typedef logic [8:0] word_t;

    // which side the transceiver faces
    typedef enum logic [1:0] {
        drive_none = 2'b01,
        drive_side = 2'b10
    } drive_state_t;

endpackage : bidir_fifo_pkg

`default_nettype wire

/* File: hdl/bidir_fifo_regs.svh */
`ifndef BIDIR_FIFO_REGS_SVH
`define BIDIR_FIFO_REGS_SVH

`define FIFO_WIDTH          9
`define FIFO_DEPTH          1024
`define FIFO_PTR_BITS       10
`define FIFO_COUNT_BITS     11
`define HALF_FULL_WORDS     11'h0200
`define DEFAULT_OFFSET      9'h100
`define OUT_QUEUE_DEPTH     8
`define PIN_IDLE_LEVELS     11'h278

`endif

/* File: hdl/dual_bidir_fifo_transceiver.sv */
`include "bidir_fifo_regs.svh"
`default_nettype none

module dual_bidir_fifo_transceiver #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int QDEPTH = `OUT_QUEUE_DEPTH
) (
    input  wire logic                i_clock,
    input  wire logic                i_reset_n,
    input  wire bidir_fifo_pkg::word_t i_port_a_data,
    output bidir_fifo_pkg::word_t    o_port_a_data,
    output logic                     o_port_a_data_oe_n,
    input  wire bidir_fifo_pkg::word_t i_port_b_data,
    output bidir_fifo_pkg::word_t    o_port_b_data,
    output logic                     o_port_b_data_oe_n,
    input  wire logic                i_load_clock_a_side,
    input  wire logic                i_load_clock_b_side,
    input  wire logic                i_unload_clock_a_side,
    input  wire logic                i_unload_clock_b_side,
    input  wire logic                i_define_flag_a_n,
    input  wire logic                i_define_flag_b_n,
    input  wire logic                i_reset_a_to_b_n,
    input  wire logic                i_reset_b_to_a_n,
    input  wire logic                i_select_stored_to_b,
    input  wire logic                i_select_stored_to_a,
    input  wire logic                i_output_enable_n,
    input  wire logic                i_direction,
    output logic                     o_empty_flag_a_n,
    output logic                     o_empty_flag_b_n,
    output logic                     o_full_flag_a_n,
    output logic                     o_full_flag_b_n,
    output logic                     o_half_full_flag_a,
    output logic                     o_half_full_flag_b,
    output logic                     o_almost_flag_a,
    output logic                     o_almost_flag_b,
    output logic                     o_stored_valid_b,
    input  wire logic                i_stored_ready_b,
    output logic                     o_stored_valid_a,
    input  wire logic                i_stored_ready_a
);

    import bidir_fifo_pkg::*;

    // ****************************************************************
    // input synchronisers: three stages, change counted when 2 and 3 agree
    // ****************************************************************
    localparam int NSYNC = 11;
    localparam int NSTRB = 3;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] pin_level;
    logic [NSYNC-1:0] next_level;
    logic [NSTRB-1:0] rise;
    logic [1:0]       def_fall;
    word_t            a_sync1;
    word_t            a_sync2;
    word_t            a_in;
    word_t            b_sync1;
    word_t            b_sync2;
    word_t            b_in;

    assign pin_raw = {i_direction, i_output_enable_n, i_select_stored_to_a, i_select_stored_to_b,
                      i_define_flag_b_n, i_define_flag_a_n, i_reset_b_to_a_n, i_reset_a_to_b_n,
                      i_unload_clock_b_side, i_load_clock_b_side, i_load_clock_a_side};

    // reset to the idle pin levels, so no false edge follows reset
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1     <= `PIN_IDLE_LEVELS;
            sync2     <= `PIN_IDLE_LEVELS;
            sync3     <= `PIN_IDLE_LEVELS;
            pin_level <= `PIN_IDLE_LEVELS;
        end else begin
            sync1     <= pin_raw;
            sync2     <= sync1;
            sync3     <= sync2;
            pin_level <= next_level;
        end
    end

    // data buses pass three stages so they align with the strobes
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_sync1 <= '0;
            a_sync2 <= '0;
            a_in    <= '0;
            b_sync1 <= '0;
            b_sync2 <= '0;
            b_in    <= '0;
        end else begin
            a_sync1 <= i_port_a_data;
            a_sync2 <= a_sync1;
            a_in    <= a_sync2;
            b_sync1 <= i_port_b_data;
            b_sync2 <= b_sync1;
            b_in    <= b_sync2;
        end
    end

    // pin map: 0 load a, 1 load b, 2 unload b, 3-4 direction resets,
    // 5-6 define flags, 7-8 selects, 9 output enable, 10 direction
    // a level moves only once stages 2 and 3 agree
    logic [NSYNC-1:0] prev_level;
    always_comb begin
        next_level = pin_level;
        for (int i = 0; i < NSYNC; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_level[i] = sync3[i];
            end
        end
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_level <= `PIN_IDLE_LEVELS;
        end else begin
            prev_level <= pin_level;
        end
    end

    // edges seen on the settled levels
    generate
        for (genvar g = 0; g < NSTRB; g++) begin : g_rise
            assign rise[g] = pin_level[g] && !prev_level[g];
        end
    endgenerate
    assign def_fall = prev_level[6:5] & ~pin_level[6:5];

    // unload clocks: the a-to-b FIFO is drained by the b side strobe,
    // the b-to-a FIFO by the a side strobe
    logic unload_a_sync1;
    logic unload_a_sync2;
    logic unload_a_sync3;
    logic unload_a_level;
    logic unload_a_prev;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            unload_a_sync1 <= 1'b0;
            unload_a_sync2 <= 1'b0;
            unload_a_sync3 <= 1'b0;
            unload_a_level <= 1'b0;
            unload_a_prev  <= 1'b0;
        end else begin
            unload_a_sync1 <= i_unload_clock_a_side;
            unload_a_sync2 <= unload_a_sync1;
            unload_a_sync3 <= unload_a_sync2;
            if (unload_a_sync2 == unload_a_sync3) begin
                unload_a_level <= unload_a_sync3;
            end
            unload_a_prev <= unload_a_level;
        end
    end

    // ****************************************************************
    // two direction channels
    // ****************************************************************
    logic [1:0] wr_stb;
    logic [1:0] rd_stb;
    logic [1:0] dir_reset_n;
    logic [1:0] def_level_n;
    logic [1:0] stored_ready;
    word_t      wr_data [2];
    word_t      held_word [2];
    logic [1:0] out_valid;
    logic [1:0] empty_n;
    logic [1:0] full_n;
    logic [1:0] half;
    logic [1:0] almost;
    logic [1:0] stored_valid;

    assign wr_stb       = rise[1:0];
    assign rd_stb       = {unload_a_level && !unload_a_prev, rise[2]};
    assign dir_reset_n  = pin_level[4:3];
    assign def_level_n  = pin_level[6:5];
    assign wr_data[0]   = a_in;
    assign wr_data[1]   = b_in;
    assign stored_ready = {i_stored_ready_a, i_stored_ready_b};
    assign stored_valid = {o_stored_valid_a, o_stored_valid_b};

    generate
        for (genvar d = 0; d < 2; d++) begin : g_dir
            logic [`FIFO_WIDTH-1:0]      mem [DEPTH];
            logic [`FIFO_PTR_BITS-1:0]   wptr;
            logic [`FIFO_PTR_BITS-1:0]   rptr;
            logic [`FIFO_COUNT_BITS-1:0] count;
            logic [`FIFO_WIDTH-1:0]      captured;
            logic [`FIFO_WIDTH-1:0]      offset;
            logic                        reset_prev_n;
            logic                        do_wr;
            logic                        do_rd;
            logic                        q_ready;
            logic [`FIFO_COUNT_BITS-1:0] off_ext;

            // a full FIFO refuses writes, an empty or blocked one refuses reads
            assign do_wr   = wr_stb[d] && (count != `FIFO_COUNT_BITS'(DEPTH));
            assign do_rd   = rd_stb[d] && (count != '0) && q_ready;
            assign off_ext = `FIFO_COUNT_BITS'(offset);

            always_ff @(posedge i_clock) begin
                if (do_wr) begin
                    mem[wptr] <= wr_data[d];
                end
            end

            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    wptr  <= '0;
                    rptr  <= '0;
                    count <= '0;
                end else if (!dir_reset_n[d]) begin
                    wptr  <= '0;
                    rptr  <= '0;
                    count <= '0;
                end else begin
                    if (do_wr) begin
                        wptr <= wptr + 1'b1;
                    end
                    if (do_rd) begin
                        rptr <= rptr + 1'b1;
                    end
                    count <= count + `FIFO_COUNT_BITS'(do_wr) - `FIFO_COUNT_BITS'(do_rd);
                end
            end

            // offset captured on define-flag fall, applied when reset releases
            // define-flag still high at release selects the default offset
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    captured     <= `DEFAULT_OFFSET;
                    offset       <= `DEFAULT_OFFSET;
                    reset_prev_n <= 1'b1;
                end else begin
                    reset_prev_n <= dir_reset_n[d];
                    if (def_fall[d]) begin
                        captured <= wr_data[d];
                    end
                    if (dir_reset_n[d] && !reset_prev_n) begin
                        offset <= def_level_n[d] ? `DEFAULT_OFFSET : captured;
                    end
                end
            end

            // last read word held; stays when the FIFO empties
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    held_word[d] <= '0;
                end else if (do_rd) begin
                    held_word[d] <= mem[rptr];
                end
            end

            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    empty_n[d] <= 1'b0;
                    full_n[d]  <= 1'b1;
                    half[d]    <= 1'b0;
                    almost[d]  <= 1'b1;
                end else begin
                    empty_n[d] <= (count != '0);
                    full_n[d]  <= (count != `FIFO_COUNT_BITS'(DEPTH));
                    half[d]    <= (count >= `HALF_FULL_WORDS);
                    almost[d]  <= (count <= off_ext) ||
                                  (count >= `FIFO_COUNT_BITS'(DEPTH) - off_ext);
                end
            end

            // unloaded words also enter a small queue; only its valid streams out, its data output is unconnected
            stream_fifo #(
                .WIDTH (`FIFO_WIDTH),
                .DEPTH (QDEPTH)
            ) u_queue (
                .i_clock     (i_clock),
                .i_reset_n   (i_reset_n),
                .i_in_valid  (do_rd),
                .o_in_ready  (q_ready),
                .i_in_data   (mem[rptr]),
                .o_out_valid (out_valid[d]),
                .i_out_ready (stored_ready[d] && stored_valid[d]),
                .o_out_data  ()
            );
        end
    endgenerate

    // ****************************************************************
    // flags and transceiver outputs, all registered
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_empty_flag_a_n   <= 1'b0;
            o_empty_flag_b_n   <= 1'b0;
            o_full_flag_a_n    <= 1'b1;
            o_full_flag_b_n    <= 1'b1;
            o_half_full_flag_a <= 1'b0;
            o_half_full_flag_b <= 1'b0;
            o_almost_flag_a    <= 1'b1;
            o_almost_flag_b    <= 1'b1;
            o_stored_valid_b   <= 1'b0;
            o_stored_valid_a   <= 1'b0;
        end else begin
            o_empty_flag_a_n   <= empty_n[0];
            o_empty_flag_b_n   <= empty_n[1];
            o_full_flag_a_n    <= full_n[0];
            o_full_flag_b_n    <= full_n[1];
            o_half_full_flag_a <= half[0];
            o_half_full_flag_b <= half[1];
            o_almost_flag_a    <= almost[0];
            o_almost_flag_b    <= almost[1];
            // one idle cycle after each hand-over keeps valid in step with the queue
            o_stored_valid_b   <= out_valid[0] && !(i_stored_ready_b && o_stored_valid_b);
            o_stored_valid_a   <= out_valid[1] && !(i_stored_ready_a && o_stored_valid_a);
        end
    end

    // a registered mux switches cleanly between live and stored words
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_b_data <= '0;
            o_port_a_data <= '0;
        end else begin
            o_port_b_data <= pin_level[7] ? held_word[0] : a_in;
            o_port_a_data <= pin_level[8] ? held_word[1] : b_in;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_a_data_oe_n <= 1'b1;
            o_port_b_data_oe_n <= 1'b1;
        end else begin
            // direction high drives b, low drives a; enable high releases both
            o_port_a_data_oe_n <= pin_level[9] || pin_level[10];
            o_port_b_data_oe_n <= pin_level[9] || !pin_level[10];
        end
    end

endmodule : dual_bidir_fifo_transceiver

`default_nettype wire

/* File: hdl/stream_fifo.sv */
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign push        = i_in_valid && (count != (AW+1)'(DEPTH));
    assign pop         = i_out_ready && (count != '0);
    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = store[rd_ptr];

    always_ff @(posedge i_clock) begin
        if (push) begin
            store[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : stream_fifo

`default_nettype wire

/* File: verification/dual_bidir_fifo_transceiver_bench.sv */
`default_nettype none
module dual_bidir_fifo_transceiver_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import bidir_fifo_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_reset_n, rst_ab_n, rst_ba_n, def_a_n, def_b_n, sel_a, sel_b, oe_n, dir;
    logic [3:0]  stb;
    logic        ready_a, ready_b, valid_a, valid_b, a_oe_n, b_oe_n;
    logic        empty_a_n, empty_b_n, full_a_n, full_b_n, half_a, half_b, almost_a, almost_b;
    word_t       a_drv, b_drv, a_out, b_out, a_wire, b_wire, w;
    logic [15:0] taken_a, taken_b;
    int          miscompares = 0;
    int          comparisons = 0;
    int          offset;
    word_t       q[$];
    always #4 i_clock = ~i_clock;
    assign a_wire = a_oe_n ? a_drv : a_out;
    assign b_wire = b_oe_n ? b_drv : b_out;
    dual_bidir_fifo_transceiver dut (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_port_a_data(a_wire), .o_port_a_data(a_out),
        .o_port_a_data_oe_n(a_oe_n), .i_port_b_data(b_wire), .o_port_b_data(b_out),
        .o_port_b_data_oe_n(b_oe_n), .i_load_clock_a_side(stb[0]), .i_load_clock_b_side(stb[1]),
        .i_unload_clock_a_side(stb[2]), .i_unload_clock_b_side(stb[3]), .i_define_flag_a_n(def_a_n),
        .i_define_flag_b_n(def_b_n), .i_reset_a_to_b_n(rst_ab_n), .i_reset_b_to_a_n(rst_ba_n),
        .i_select_stored_to_b(sel_b), .i_select_stored_to_a(sel_a), .i_output_enable_n(oe_n),
        .i_direction(dir), .o_empty_flag_a_n(empty_a_n), .o_empty_flag_b_n(empty_b_n),
        .o_full_flag_a_n(full_a_n), .o_full_flag_b_n(full_b_n), .o_half_full_flag_a(half_a),
        .o_half_full_flag_b(half_b), .o_almost_flag_a(almost_a), .o_almost_flag_b(almost_b),
        .o_stored_valid_b(valid_b), .i_stored_ready_b(ready_b), .o_stored_valid_a(valid_a),
        .i_stored_ready_a(ready_a)
    );
    far_host_model host (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_valid_a(valid_a), .i_valid_b(valid_b),
        .o_ready_a(ready_a), .o_ready_b(ready_b), .o_taken_a(taken_a), .o_taken_b(taken_b)
    );
    // ****
    // shared tasks
    // ****
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cycles
    // strobes held five cycles high and five low
    task automatic pulse(input int k);
        stb[k] = 1'b1;
        cycles(5);
        stb[k] = 1'b0;
        cycles(5);
    endtask : pulse
    function automatic logic near(input int n, input int x);
        return n <= x || n >= 1024 - x;
    endfunction : near
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // ****
    // scenarios
    // ****
    initial begin
        {i_reset_n, rst_ab_n, rst_ba_n, stb, sel_a, sel_b, dir} = '0;
        {def_a_n, def_b_n, oe_n} = 3'h7;
        a_drv = '0;
        b_drv = '0;
        void'($urandom(32'hb376));
        cycles(2);
        i_reset_n = 1'b1;
        cycles(10);
        check("empty_a", empty_a_n, 1'b0);
        {rst_ab_n, rst_ba_n} = 2'h3;
        cycles(8);
        check("full_a", full_a_n, 1'b1);
        check("almost_a", almost_a, 1'b1);
        check("oe_off", {a_oe_n, b_oe_n}, 2'h3);
        for (int i = 0; i < 5; i++) begin
            a_drv = word_t'($urandom);
            q.push_back(a_drv);
            pulse(0);
        end
        cycles(10);
        check("empty_a", empty_a_n, 1'b1);
        check("half_a", half_a, 1'b0);
        {sel_b, oe_n, dir} = 3'h5;
        for (int i = 0; i < 5; i++) begin
            w = q.pop_front();
            pulse(3);
            check("b_stored", b_out, w);
        end
        check("oe_dir_b", {a_oe_n, b_oe_n}, 2'h2);
        cycles(10);
        check("empty_a", empty_a_n, 1'b0);
        pulse(3);
        check("b_held", b_out, w);
        cycles(10);
        sel_b = 1'b0;
        a_drv = word_t'($urandom);
        cycles(8);
        check("b_live", b_out, a_drv);
        check("taken_b", taken_b, 16'h0005);
        dir = 1'b0;
        b_drv = word_t'($urandom);
        cycles(12);
        check("oe_dir_a", {a_oe_n, b_oe_n}, 2'h1);
        check("a_live", a_out, b_drv);
        oe_n = 1'b1;
        cycles(6);
        check("oe_off", {a_oe_n, b_oe_n}, 2'h3);
        for (int n = 1; n <= 1024; n++) begin
            a_drv = word_t'(n);
            pulse(0);
            check("half_a", half_a, n >= 512);
            check("almost_a", almost_a, near(n, 256));
            check("full_a", full_a_n, n != 1024);
        end
        a_drv = 9'h1ff;
        pulse(0);
        check("full_a", full_a_n, 1'b0);
        {sel_b, oe_n, dir} = 3'h5;
        pulse(3);
        check("b_first", b_out, 9'h001);
        check("full_a", full_a_n, 1'b1);
        oe_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            pulse(1);
        end
        offset = $urandom_range(40, 1);
        b_drv = word_t'(offset);
        cycles(2);
        def_b_n = 1'b0;
        cycles(6);
        rst_ba_n = 1'b0;
        cycles(10);
        check("reset_b", {empty_b_n, full_b_n, almost_b, half_b}, 4'h6);
        rst_ba_n = 1'b1;
        cycles(8);
        def_b_n = 1'b1;
        b_drv = '0;
        cycles(4);
        def_b_n = 1'b0;
        cycles(6);
        for (int n = 1; n <= offset + 2; n++) begin
            b_drv = word_t'(n);
            pulse(1);
            check("almost_b", almost_b, near(n, offset));
        end
        {sel_a, oe_n, dir} = 3'h4;
        pulse(2);
        check("a_stored", a_out, 9'h001);
        check("taken_a", taken_a, 16'h0001);
        give_verdict();
    end
    initial begin
        cycles(20000);
        miscompares++;
        give_verdict();
    end
endmodule : dual_bidir_fifo_transceiver_bench
`default_nettype wire

/* File: verification/far_host_model.sv */
`default_nettype none
// ****
// hosts draining the unloaded words
// ****
module far_host_model (
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    input  wire logic        i_valid_a,
    input  wire logic        i_valid_b,
    output logic             o_ready_a,
    output logic             o_ready_b,
    output logic      [15:0] o_taken_a,
    output logic      [15:0] o_taken_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase;
    // each side stalls two cycles of eight, out of step with the other
    assign o_ready_a = phase[2:1] != 2'h3;
    assign o_ready_b = phase[2:1] != 2'h0;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= 3'h0;
            o_taken_a <= 16'h0000;
            o_taken_b <= 16'h0000;
        end else begin
            phase <= phase + 3'h1;
            o_taken_a <= o_taken_a + 16'(i_valid_a && o_ready_a);
            o_taken_b <= o_taken_b + 16'(i_valid_b && o_ready_b);
        end
    end
endmodule : far_host_model
`default_nettype wire

/* File: verification/fifo_port_monitor.sv */
`default_nettype none
// ****
// port checker for the transceiver
// ****
module fifo_port_monitor (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset_n,
    input  wire bidir_fifo_pkg::word_t i_port_a_data,
    input  wire bidir_fifo_pkg::word_t o_port_b_data,
    input  wire logic                  o_port_a_data_oe_n,
    input  wire logic                  o_port_b_data_oe_n,
    input  wire logic                  i_unload_clock_b_side,
    input  wire logic                  i_reset_a_to_b_n,
    input  wire logic                  i_select_stored_to_b,
    input  wire logic                  i_output_enable_n,
    input  wire logic                  i_direction,
    input  wire logic                  o_empty_flag_a_n,
    input  wire logic                  o_full_flag_a_n,
    input  wire logic                  o_half_full_flag_a,
    input  wire logic                  o_almost_flag_a
);
    timeunit 1ns;
    timeprecision 1ps;
    import bidir_fifo_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // a pin reaches the registered outputs four edges after it is sampled
    oe_off_a: assert property (i_output_enable_n [*6]
        |-> o_port_a_data_oe_n && o_port_b_data_oe_n) else $error("bus driven while disabled");
    dir_b_a: assert property ((!i_output_enable_n && i_direction) [*6]
        |-> !o_port_b_data_oe_n && o_port_a_data_oe_n) else $error("direction high wrong bus");
    dir_a_a: assert property ((!i_output_enable_n && !i_direction) [*6]
        |-> !o_port_a_data_oe_n && o_port_b_data_oe_n) else $error("direction low wrong bus");
    flags_apart_a: assert property (o_empty_flag_a_n || o_full_flag_a_n) else $error("empty and full together");
    full_flags_a: assert property (!o_full_flag_a_n
        |-> o_half_full_flag_a && o_almost_flag_a && o_empty_flag_a_n) else $error("flags wrong when full");
    empty_flags_a: assert property (!o_empty_flag_a_n
        |-> o_almost_flag_a && !o_half_full_flag_a) else $error("flags wrong when empty");
    reset_flags_a: assert property (!i_reset_a_to_b_n [*8]
        |-> !o_empty_flag_a_n && o_full_flag_a_n && o_almost_flag_a) else $error("flags wrong in reset");
    live_pass_a: assert property ((!i_select_stored_to_b && $stable(i_port_a_data)) [*6]
        |-> o_port_b_data == i_port_a_data) else $error("live data not passed");
    stored_hold_a: assert property ((i_select_stored_to_b && !i_unload_clock_b_side) [*8]
        |-> $stable(o_port_b_data)) else $error("stored word moved");
endmodule : fifo_port_monitor

bind dual_bidir_fifo_transceiver fifo_port_monitor monitor (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_port_a_data(i_port_a_data),
    .o_port_b_data(o_port_b_data), .o_port_a_data_oe_n(o_port_a_data_oe_n),
    .o_port_b_data_oe_n(o_port_b_data_oe_n), .i_unload_clock_b_side(i_unload_clock_b_side),
    .i_reset_a_to_b_n(i_reset_a_to_b_n), .i_select_stored_to_b(i_select_stored_to_b),
    .i_output_enable_n(i_output_enable_n), .i_direction(i_direction),
    .o_empty_flag_a_n(o_empty_flag_a_n), .o_full_flag_a_n(o_full_flag_a_n),
    .o_half_full_flag_a(o_half_full_flag_a), .o_almost_flag_a(o_almost_flag_a)
);
`default_nettype wire
